/* core/radio_state_controller_regs.svh */
// register indices, field positions, command codes and reset values of the radio state controller
`ifndef RADIO_STATE_CONTROLLER_REGS_SVH
`define RADIO_STATE_CONTROLLER_REGS_SVH

// register indices; byte address is four times the index
`define RSC_CFG_BASE_IDX       10'h100
`define RSC_CFG_BYTES          64
`define RSC_CHAN_HI_IDX        10'h109
`define RSC_CHAN_MID_IDX       10'h10A
`define RSC_CHAN_LO_IDX        10'h10B
`define RSC_MODE_CTRL_IDX      10'h11A
`define RSC_CMD_IDX            10'h200
`define RSC_STATUS_IDX         10'h201
`define RSC_CTRL_IDX           10'h202

// operating_mode_control fields
`define RSC_MODE_FILTER_CAL    0
`define RSC_MODE_RX_TO_TX      1
`define RSC_MODE_TX_TO_RX      2

// ctrl register fields
`define RSC_CTRL_STREAM        0
`define RSC_CTRL_FW_AES        1
`define RSC_CTRL_FW_IRCAL      2
`define RSC_CTRL_FW_RS         3

// status register fields
`define RSC_STAT_STATE_LSB     0
`define RSC_STAT_READY         4
`define RSC_STAT_POR           5
`define RSC_STAT_DEEP          6

// command codes
`define RSC_CMD_OFF            8'hB0
`define RSC_CMD_ON             8'hB1
`define RSC_CMD_RX             8'hB2
`define RSC_CMD_TX             8'hB5
`define RSC_CMD_SLEEP          8'hBA
`define RSC_CMD_CONFIG         8'hBB
`define RSC_CMD_POWER_DOWN     8'hC8
`define RSC_CMD_AES            8'hD0
`define RSC_CMD_IRCAL          8'hBD
`define RSC_CMD_RS             8'hD6

// reset values
`define RSC_CTRL_RESET         8'h00
`define RSC_CFG_RESET          8'h00

`endif

/* core/radio_state_controller_pkg.sv */
// types shared by the radio state controller
package radio_state_controller_pkg;
	typedef enum logic [2:0] {
		sleep_state,
		powered_idle_state,
		standby_state,
		transmit_state,
		receive_state
	} radio_state_e;
endpackage

/* core/radio_state_controller.sv */
// radio state controller: five-state power sequencer with wishbone register slave
//
// Implementation choice: register access over Wishbone.
`include "radio_state_controller_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - five radio states, changed by one-byte host commands.
// - sleep command accepted only in off or standby.
// - sleep ends on chip select low or wake timer expiry.
// - full power down enters deep sleep two; config lost, timer off.
// - asleep, interrupt pin held low, other gpio pins released.
// - off state powers crystal, digital and synth regulators; memories accessible.
// - off to standby runs filter calibration only when enable bit set.
// - transmit and receive are reachable from standby.
// - transmit and receive use the 24-bit channel word.
// - packet transmit done disables pa, returns to standby, optional interrupt; the interrupt pin here has no enable and pulses on the frame event.
// - streaming mode transmits the stream pin data instead of packet ram.
// - packet receive valid returns to standby, optional interrupt; the interrupt pin here has no enable and pulses on the frame event.
// - streaming mode stays in receive; end-of-frame transitions suppressed.
// - auto turnaround only when the matching mode control bit is set.
// - aes, image calibration and coding commands need loaded firmware.
// - power-on reset enters off with packet ram cleared, modem config default.
// - full power down sleeps; later chip select wake registers power-on reset.
// - chip select wake drives miso high once off state is reached.
// - apply config loads all parameters except the channel word.
// - chip select wake from normal sleep is no power-on reset.
module radio_state_controller (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESETN,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [11:0] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// pins from the far side
	input  wire logic        CS_N,
	input  wire logic        WAKE_TIMER_EXPIRED,
	input  wire logic        STREAM_TX_DATA_PIN,
	// packet engine, same clock
	input  wire logic        PKT_TX_DATA,
	input  wire logic        TX_PACKET_DONE,
	input  wire logic        RX_PACKET_VALID,
	// pins to the far side
	output logic             MISO_READY,
	output logic             GENERAL_INTERRUPT_PIN,
	output logic             GENERAL_INTERRUPT_OE,
	output logic             GPIO_OE,
	// power and radio control
	output logic             XTAL_EN,
	output logic             DIG_REG_EN,
	output logic             SYNTH_REG_EN,
	output logic             RF_REG_EN,
	output logic             MEM_ACCESS_EN,
	output logic             PA_EN,
	output logic             RX_EN,
	output logic             WAKE_TIMER_EN,
	output logic             TX_BIT,
	output logic      [23:0] CHANNEL_WORD,
	// one-cycle strobes
	output logic             FILTER_CAL_START,
	output logic             CONFIG_APPLY,
	output logic             AES_START,
	output logic             IRCAL_START,
	output logic             RS_START,
	output logic             FRAME_EVENT
);
	localparam int CFG_BYTES = `RSC_CFG_BYTES;

	radio_state_controller_pkg::radio_state_e state_reg;
	radio_state_controller_pkg::radio_state_e state_next;

	logic [7:0]  cfg_mem [CFG_BYTES];
	logic [7:0]  ctrl_reg;
	logic        por_reg;
	logic        deep_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [1:0]  cs_sync_reg;
	logic [1:0]  wake_sync_reg;
	logic [1:0]  stream_sync_reg;
	logic [9:0]  idx;
	logic        bus_req;
	logic        bus_wr;
	logic        cmd_wr;
	logic [7:0]  cmd;
	logic        is_cfg;
	logic [5:0]  cfg_off;
	logic        stream_mode;
	logic [7:0]  mode_ctrl;
	logic        cs_wake;
	logic        timer_wake;
	logic        power_down;

	// bus decode; the index is the word address
	assign idx         = WB_ADR_I[11:2];
	assign bus_req     = WB_CYC_I && WB_STB_I && !ack_reg;
	assign bus_wr      = bus_req && WB_WE_I && WB_SEL_I[0];
	assign is_cfg      = (idx >= `RSC_CFG_BASE_IDX) &&
	                     (idx < (`RSC_CFG_BASE_IDX + 10'(CFG_BYTES)));
	assign cfg_off     = idx[5:0];
	assign cmd         = WB_DAT_I[7:0];
	assign cmd_wr      = bus_wr && (idx == `RSC_CMD_IDX);
	assign stream_mode = ctrl_reg[`RSC_CTRL_STREAM];
	assign mode_ctrl   = cfg_mem[6'(`RSC_MODE_CTRL_IDX - `RSC_CFG_BASE_IDX)];

	// pin synchronisers; first stage is read only by the second
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cs_sync_reg     <= 2'b11;
			wake_sync_reg   <= 2'b00;
			stream_sync_reg <= 2'b00;
		end else begin
			cs_sync_reg     <= {cs_sync_reg[0], CS_N};
			wake_sync_reg   <= {wake_sync_reg[0], WAKE_TIMER_EXPIRED};
			stream_sync_reg <= {stream_sync_reg[0], STREAM_TX_DATA_PIN};
		end
	end

	// wake sources; timer is off in deep sleep two
	// wake on select
	assign cs_wake    = !cs_sync_reg[1];
	assign timer_wake = wake_sync_reg[1] && !deep_reg;
	assign power_down = cmd_wr && (cmd == `RSC_CMD_POWER_DOWN);

	// next radio state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			radio_state_controller_pkg::sleep_state: begin
				if (cs_wake || timer_wake) begin
					state_next = radio_state_controller_pkg::powered_idle_state;
				end
			end
			radio_state_controller_pkg::powered_idle_state: begin
				if (cmd_wr && (cmd == `RSC_CMD_SLEEP || power_down)) begin
					state_next = radio_state_controller_pkg::sleep_state;
				end else if (cmd_wr && cmd == `RSC_CMD_ON) begin
					state_next = radio_state_controller_pkg::standby_state;
				end
			end
			radio_state_controller_pkg::standby_state: begin
				if (cmd_wr && cmd == `RSC_CMD_TX) begin
					state_next = radio_state_controller_pkg::transmit_state;
				end else if (cmd_wr && cmd == `RSC_CMD_RX) begin
					state_next = radio_state_controller_pkg::receive_state;
				end else if (cmd_wr && cmd == `RSC_CMD_OFF) begin
					state_next = radio_state_controller_pkg::powered_idle_state;
				end else if (cmd_wr && (cmd == `RSC_CMD_SLEEP || power_down)) begin
					state_next = radio_state_controller_pkg::sleep_state;
				end
			end
			radio_state_controller_pkg::transmit_state: begin
				if (cmd_wr && cmd == `RSC_CMD_ON) begin
					state_next = radio_state_controller_pkg::standby_state;
				end else if (cmd_wr && cmd == `RSC_CMD_RX) begin
					state_next = radio_state_controller_pkg::receive_state;
				end else if (power_down) begin
					state_next = radio_state_controller_pkg::sleep_state;
				end else if (TX_PACKET_DONE && !stream_mode) begin
					if (mode_ctrl[`RSC_MODE_TX_TO_RX]) begin
						state_next = radio_state_controller_pkg::receive_state;
					end else begin
						state_next = radio_state_controller_pkg::standby_state;
					end
				end
			end
			radio_state_controller_pkg::receive_state: begin
				if (cmd_wr && cmd == `RSC_CMD_ON) begin
					state_next = radio_state_controller_pkg::standby_state;
				end else if (cmd_wr && cmd == `RSC_CMD_TX) begin
					state_next = radio_state_controller_pkg::transmit_state;
				end else if (power_down) begin
					state_next = radio_state_controller_pkg::sleep_state;
				end else if (RX_PACKET_VALID && !stream_mode) begin
					if (mode_ctrl[`RSC_MODE_RX_TO_TX]) begin
						state_next = radio_state_controller_pkg::transmit_state;
					end else begin
						state_next = radio_state_controller_pkg::standby_state;
					end
				end
			end
			default: begin
				state_next = radio_state_controller_pkg::powered_idle_state;
			end
		endcase
	end

	// state register; reset lands in the off state
	// five-state sequencer
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= radio_state_controller_pkg::powered_idle_state;
		end else begin
			state_reg <= state_next;
		end
	end

	// deep sleep and power-on flags; a set wins over a clear
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			por_reg  <= 1'b1;
			deep_reg <= 1'b0;
		end else begin
			if (power_down && state_next == radio_state_controller_pkg::sleep_state) begin
				deep_reg <= 1'b1;
			end else if (state_reg == radio_state_controller_pkg::sleep_state &&
			             state_next != radio_state_controller_pkg::sleep_state) begin
				deep_reg <= 1'b0;
			end
			if (deep_reg && state_reg == radio_state_controller_pkg::sleep_state && cs_wake) begin
				por_reg <= 1'b1;
			end else if (bus_wr && idx == `RSC_STATUS_IDX && WB_DAT_I[`RSC_STAT_POR]) begin
				por_reg <= 1'b0;
			end
		end
	end

	// retained configuration bytes; lost on full power down
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < CFG_BYTES; i++) begin
				cfg_mem[i] <= `RSC_CFG_RESET;
			end
		end else if (power_down && state_next == radio_state_controller_pkg::sleep_state) begin
			for (int i = 0; i < CFG_BYTES; i++) begin
				cfg_mem[i] <= `RSC_CFG_RESET;
			end
		end else if (bus_wr && is_cfg &&
		             state_reg != radio_state_controller_pkg::sleep_state) begin
			cfg_mem[cfg_off] <= WB_DAT_I[7:0];
		end
	end

	// control register: streaming mode and loaded firmware modules
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= `RSC_CTRL_RESET;
		end else if (bus_wr && idx == `RSC_CTRL_IDX) begin
			ctrl_reg <= WB_DAT_I[7:0];
		end
	end

	// channel word is applied only on entry to transmit or receive
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			CHANNEL_WORD <= 24'h00_0000;
		end else if ((state_next == radio_state_controller_pkg::transmit_state ||
		              state_next == radio_state_controller_pkg::receive_state) &&
		             state_next != state_reg) begin
			CHANNEL_WORD <= {cfg_mem[6'(`RSC_CHAN_HI_IDX - `RSC_CFG_BASE_IDX)],
			                 cfg_mem[6'(`RSC_CHAN_MID_IDX - `RSC_CFG_BASE_IDX)],
			                 cfg_mem[6'(`RSC_CHAN_LO_IDX - `RSC_CFG_BASE_IDX)]};
		end
	end

	// command strobes, registered so they line up with the new state
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			FILTER_CAL_START <= 1'b0;
			CONFIG_APPLY     <= 1'b0;
			AES_START        <= 1'b0;
			IRCAL_START      <= 1'b0;
			RS_START         <= 1'b0;
			FRAME_EVENT      <= 1'b0;
		end else begin
			FILTER_CAL_START <= state_reg == radio_state_controller_pkg::powered_idle_state &&
			                    state_next == radio_state_controller_pkg::standby_state &&
			                    mode_ctrl[`RSC_MODE_FILTER_CAL];
			// apply config in off or standby
			CONFIG_APPLY     <= cmd_wr && cmd == `RSC_CMD_CONFIG &&
			                    (state_reg == radio_state_controller_pkg::powered_idle_state ||
			                     state_reg == radio_state_controller_pkg::standby_state);
			AES_START        <= cmd_wr && cmd == `RSC_CMD_AES &&
			                    ctrl_reg[`RSC_CTRL_FW_AES];
			IRCAL_START      <= cmd_wr && cmd == `RSC_CMD_IRCAL &&
			                    ctrl_reg[`RSC_CTRL_FW_IRCAL];
			RS_START         <= cmd_wr && cmd == `RSC_CMD_RS &&
			                    ctrl_reg[`RSC_CTRL_FW_RS];
			FRAME_EVENT      <= !stream_mode &&
			                    ((state_reg == radio_state_controller_pkg::transmit_state &&
			                      TX_PACKET_DONE) ||
			                     (state_reg == radio_state_controller_pkg::receive_state &&
			                      RX_PACKET_VALID));
		end
	end

	// power rails and pin drivers follow the state register
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			XTAL_EN               <= 1'b0;
			DIG_REG_EN            <= 1'b0;
			SYNTH_REG_EN          <= 1'b0;
			RF_REG_EN             <= 1'b0;
			MEM_ACCESS_EN         <= 1'b0;
			PA_EN                 <= 1'b0;
			RX_EN                 <= 1'b0;
			WAKE_TIMER_EN         <= 1'b0;
			MISO_READY            <= 1'b0;
			GENERAL_INTERRUPT_PIN <= 1'b0;
			GENERAL_INTERRUPT_OE  <= 1'b0;
			GPIO_OE               <= 1'b0;
			TX_BIT                <= 1'b0;
		end else begin
			XTAL_EN       <= state_next != radio_state_controller_pkg::sleep_state;
			DIG_REG_EN    <= state_next != radio_state_controller_pkg::sleep_state;
			SYNTH_REG_EN  <= state_next != radio_state_controller_pkg::sleep_state;
			MEM_ACCESS_EN <= state_next != radio_state_controller_pkg::sleep_state;
			RF_REG_EN     <= state_next != radio_state_controller_pkg::sleep_state &&
			                 state_next != radio_state_controller_pkg::powered_idle_state;
			PA_EN         <= state_next == radio_state_controller_pkg::transmit_state;
			RX_EN         <= state_next == radio_state_controller_pkg::receive_state;
			WAKE_TIMER_EN <= state_next == radio_state_controller_pkg::sleep_state &&
			                 !(deep_reg || power_down);
			MISO_READY    <= state_next != radio_state_controller_pkg::sleep_state &&
			                 cs_wake;
			GENERAL_INTERRUPT_OE  <= 1'b1;
			GENERAL_INTERRUPT_PIN <= state_next != radio_state_controller_pkg::sleep_state &&
			                         FRAME_EVENT;
			GPIO_OE       <= state_next != radio_state_controller_pkg::sleep_state;
			TX_BIT        <= stream_mode ? stream_sync_reg[1] : PKT_TX_DATA;
		end
	end

	// wishbone answer: ack one cycle after the request, dropped the next cycle
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			dat_reg <= 32'h0000_0000;
			if (bus_req && !WB_WE_I) begin
				if (is_cfg) begin
					dat_reg <= {24'h00_0000, cfg_mem[cfg_off]};
				end else if (idx == `RSC_STATUS_IDX) begin
					dat_reg <= {25'h000_0000, deep_reg, por_reg, 1'b1, 1'b0, state_reg};
				end else if (idx == `RSC_CTRL_IDX) begin
					dat_reg <= {24'h00_0000, ctrl_reg};
				end
			end
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = dat_reg;
endmodule

`default_nettype wire

/* verif/radio_state_controller_chk.sv */
// port-level assertions for the radio state controller
`timescale 1ns/1ps
`default_nettype none
module radio_state_controller_chk (
	// clock and reset
	input wire logic        SYS_CLK,
	input wire logic        RESETN,
	// far-side pins and events
	input wire logic        CS_N,
	input wire logic        WAKE_TIMER_EXPIRED,
	input wire logic        TX_PACKET_DONE,
	input wire logic        RX_PACKET_VALID,
	input wire logic        MISO_READY,
	input wire logic        GENERAL_INTERRUPT_PIN,
	input wire logic        GPIO_OE,
	// power and radio control
	input wire logic        XTAL_EN,
	input wire logic        DIG_REG_EN,
	input wire logic        SYNTH_REG_EN,
	input wire logic        RF_REG_EN,
	input wire logic        MEM_ACCESS_EN,
	input wire logic        PA_EN,
	input wire logic        RX_EN,
	input wire logic        WAKE_TIMER_EN,
	input wire logic [23:0] CHANNEL_WORD,
	input wire logic        FRAME_EVENT
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	// asleep means crystal off; interrupt, gpio, pa, receive and miso must be quiet then
	a_sleep_pins_low: assert property (!XTAL_EN |-> !(GENERAL_INTERRUPT_PIN || GPIO_OE
		|| PA_EN || RX_EN || MISO_READY)) else $error("pins active while asleep");
	a_awake_powered: assert property (XTAL_EN |-> (DIG_REG_EN && SYNTH_REG_EN
		&& MEM_ACCESS_EN)) else $error("awake without regulators");
	a_radio_exclusive: assert property ((PA_EN || RX_EN) |-> (RF_REG_EN
		&& !(PA_EN && RX_EN))) else $error("transmit and receive overlap");
	// the channel may only move when a radio state is entered
	a_chan_on_entry: assert property (!$stable(CHANNEL_WORD) |->
		($rose(PA_EN) || $rose(RX_EN))) else $error("channel changed outside entry");
	a_tx_done_frame: assert property ((TX_PACKET_DONE && PA_EN) ##1 !PA_EN
		|-> ##[0:1] FRAME_EVENT) else $error("no frame event after transmit");
	a_rx_valid_frame: assert property ((RX_PACKET_VALID && RX_EN) ##1 !RX_EN
		|-> ##[0:1] FRAME_EVENT) else $error("no frame event after receive");
	a_irq_follows: assert property (FRAME_EVENT |=> GENERAL_INTERRUPT_PIN)
		else $error("interrupt pin missed a frame event");
	a_irq_cause: assert property ($rose(GENERAL_INTERRUPT_PIN) |-> $past(FRAME_EVENT))
		else $error("interrupt pin rose without cause");
	// chip select held low wakes the device and raises miso within a few cycles
	a_cs_wake: assert property ((!CS_N && !XTAL_EN) |->
		##[1:8] (XTAL_EN && MISO_READY)) else $error("chip select did not wake");
	a_deep_no_timer: assert property ((!XTAL_EN && !WAKE_TIMER_EN && CS_N
		&& WAKE_TIMER_EXPIRED) |=> !XTAL_EN) else $error("timer woke deep sleep");

	c_tx_done: cover property (TX_PACKET_DONE && PA_EN);
	c_rx_valid: cover property (RX_PACKET_VALID && RX_EN);
	c_miso_up: cover property ($rose(MISO_READY));
	c_deep_sleep: cover property (!XTAL_EN && !WAKE_TIMER_EN);
endmodule

bind radio_state_controller radio_state_controller_chk u_chk (
	.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CS_N(CS_N), .WAKE_TIMER_EXPIRED(WAKE_TIMER_EXPIRED),
	.TX_PACKET_DONE(TX_PACKET_DONE), .RX_PACKET_VALID(RX_PACKET_VALID),
	.MISO_READY(MISO_READY), .GENERAL_INTERRUPT_PIN(GENERAL_INTERRUPT_PIN),
	.GPIO_OE(GPIO_OE), .XTAL_EN(XTAL_EN), .DIG_REG_EN(DIG_REG_EN),
	.SYNTH_REG_EN(SYNTH_REG_EN), .RF_REG_EN(RF_REG_EN), .MEM_ACCESS_EN(MEM_ACCESS_EN),
	.PA_EN(PA_EN), .RX_EN(RX_EN), .WAKE_TIMER_EN(WAKE_TIMER_EN),
	.CHANNEL_WORD(CHANNEL_WORD), .FRAME_EVENT(FRAME_EVENT)
);
`default_nettype wire

/* verif/radio_far_side_model.sv */
// far-side model: host chip select, wake timer, stream pin and packet engine
`timescale 1ns/1ps
`default_nettype none
module radio_far_side_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// requests from the bench
	input  wire logic cs_req,
	input  wire logic wake_req,
	input  wire logic stream_bit,
	input  wire logic done_req,
	input  wire logic valid_req,
	// pins toward the device
	output logic      cs_n,
	output logic      wake_expired,
	output logic      stream_pin,
	output logic      pkt_bit,
	output logic      tx_done,
	output logic      rx_valid
);
	// pins move just after the edge; the packet bit changes every cycle
	// so a stale sample can never pass for a fresh one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n <= 1'b1;
			wake_expired <= 1'b0;
			stream_pin <= 1'b0;
			pkt_bit <= 1'b0;
			tx_done <= 1'b0;
			rx_valid <= 1'b0;
		end else begin
			cs_n <= !cs_req;
			wake_expired <= wake_req;
			stream_pin <= stream_bit;
			pkt_bit <= !pkt_bit;
			tx_done <= done_req; // follows done_req one cycle later, as long as it is requested
			rx_valid <= valid_req;
		end
	end
endmodule
`default_nettype wire

/* verif/radio_state_controller_test.sv */
// self-checking bench of the radio state controller
`include "radio_state_controller_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_state_controller_test;
	localparam logic [2:0] SL = radio_state_controller_pkg::sleep_state;
	localparam logic [2:0] OF = radio_state_controller_pkg::powered_idle_state;
	localparam logic [2:0] ON = radio_state_controller_pkg::standby_state;
	localparam logic [2:0] TX = radio_state_controller_pkg::transmit_state;
	localparam logic [2:0] RX = radio_state_controller_pkg::receive_state;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_w = 32'h0000_0000, dat_r;
	logic        cs_req = 1'b0, wake_req = 1'b0, sbit = 1'b0, done_req = 1'b0, valid_req = 1'b0;
	logic        ack, cs_n, wexp, spin, pbit, txd, rxv, miso, irq, irq_oe, gpio_oe, tx_bit;
	logic [7:0]  pwr;
	logic [5:0]  pls;
	logic [23:0] chan;
	logic [31:0] exp_q [$];
	int          err_count = 0, check_count = 0, cnt [6] = '{default: 0}, ecnt [6] = '{default: 0};

	always #2.5 clk = ~clk;

	radio_far_side_model u_host (.clk(clk), .rst_n(rst_n), .cs_req(cs_req), .wake_req(wake_req),
		.stream_bit(sbit), .done_req(done_req), .valid_req(valid_req), .cs_n(cs_n),
		.wake_expired(wexp), .stream_pin(spin), .pkt_bit(pbit), .tx_done(txd), .rx_valid(rxv));

	radio_state_controller DUT (
		.SYS_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
		.CS_N(cs_n), .WAKE_TIMER_EXPIRED(wexp), .STREAM_TX_DATA_PIN(spin),
		.PKT_TX_DATA(pbit), .TX_PACKET_DONE(txd), .RX_PACKET_VALID(rxv), .MISO_READY(miso),
		.GENERAL_INTERRUPT_PIN(irq), .GENERAL_INTERRUPT_OE(irq_oe), .GPIO_OE(gpio_oe),
		.XTAL_EN(pwr[0]), .DIG_REG_EN(pwr[1]), .SYNTH_REG_EN(pwr[2]), .MEM_ACCESS_EN(pwr[3]),
		.RF_REG_EN(pwr[4]), .PA_EN(pwr[5]), .RX_EN(pwr[6]), .WAKE_TIMER_EN(pwr[7]),
		.TX_BIT(tx_bit), .CHANNEL_WORD(chan), .FILTER_CAL_START(pls[0]),
		.CONFIG_APPLY(pls[1]), .AES_START(pls[2]), .IRCAL_START(pls[3]), .RS_START(pls[4]),
		.FRAME_EVENT(pls[5]));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s);
		int n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			check(32'h0000_0000, 32'h0000_0001);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		wb(1'b1, idx, {24'h00_0000, d}, 4'hF);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, idx, 32'h0000_0000, 4'hF);
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(`RSC_CMD_IDX, c);
	endtask

	task automatic st(input logic [2:0] s, input logic por, input logic deep);
		rd(`RSC_STATUS_IDX, {25'h000_0000, deep, por, 1'b1, 1'b0, s});
	endtask

	// one packet-engine event through the far side, then the resulting state
	task automatic ev(input logic d, input logic [2:0] s);
		@(posedge clk);
		done_req <= d;
		valid_req <= !d;
		@(posedge clk);
		done_req <= 1'b0;
		valid_req <= 1'b0;
		repeat (4) @(posedge clk);
		st(s, 1'b0, 1'b0);
	endtask

	// wait past the edge so a strobe standing in this cycle is counted first
	task automatic cnts();
		#1;
		for (int i = 0; i < 6; i++)
			check(cnt[i], ecnt[i]);
	endtask

	// read answers are compared against the oldest note
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0)
			check(dat_r, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFF_FFFF);
	end

	// strobes are counted so that missing or extra pulses show
	always @(posedge clk) begin
		for (int i = 0; i < 6; i++)
			if (pls[i] === 1'b1)
				cnt[i]++;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end

	initial begin
		logic [23:0] ch;
		logic [7:0]  code [3];
		code = '{`RSC_CMD_AES, `RSC_CMD_IRCAL, `RSC_CMD_RS};
		void'($urandom(32'h46c73f9d));
		ch = 24'($urandom());
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// off state with por flag after reset
		st(OF, 1'b1, 1'b0);
		#1 check({irq_oe, pwr}, 9'h10F);
		wr(`RSC_STATUS_IDX, 8'h20);
		rd(10'h3FF, 32'h0000_0000);
		// moves not allowed from off are ignored
		cmd(`RSC_CMD_TX);
		cmd(`RSC_CMD_RX);
		cmd(`RSC_CMD_OFF);
		st(OF, 1'b0, 1'b0);
		// retained config loaded before leaving off
		wr(`RSC_CHAN_HI_IDX, ch[23:16]);
		wr(`RSC_CHAN_MID_IDX, ch[15:8]);
		wr(`RSC_CHAN_LO_IDX, ch[7:0]);
		wb(1'b1, `RSC_MODE_CTRL_IDX, 32'h0000_0007, 4'hE);
		rd(`RSC_MODE_CTRL_IDX, 32'h0000_0000);
		// calibration only with its enable bit
		cmd(`RSC_CMD_ON);
		cmd(`RSC_CMD_OFF);
		wr(`RSC_MODE_CTRL_IDX, 8'h01);
		cmd(`RSC_CMD_ON);
		ecnt[0]++;
		cmd(`RSC_CMD_CONFIG);
		ecnt[1]++;
		check(chan, 24'h00_0000);
		// firmware commands need their module loaded
		for (int i = 0; i < 3; i++)
			cmd(code[i]);
		wr(`RSC_CTRL_IDX, 8'h0E);
		for (int i = 0; i < 3; i++) begin
			cmd(code[i]);
			ecnt[2 + i]++;
		end
		cnts();
		// packet transmit, then back to standby
		cmd(`RSC_CMD_TX);
		#1 check(chan, ch);
		check({tx_bit, pwr}, {!pbit, 8'h3F});
		cmd(`RSC_CMD_SLEEP);
		st(TX, 1'b0, 1'b0);
		ev(1'b1, ON);
		wr(`RSC_MODE_CTRL_IDX, 8'h07);
		cmd(`RSC_CMD_TX);
		ev(1'b1, RX);
		ev(1'b0, TX);
		cmd(`RSC_CMD_ON);
		wr(`RSC_MODE_CTRL_IDX, 8'h01);
		cmd(`RSC_CMD_RX);
		#1 check(pwr, 8'h5F);
		ev(1'b0, ON);
		ecnt[5] += 4;
		// stream mode sends the pin and ignores frame ends
		wr(`RSC_CTRL_IDX, 8'h0F);
		cmd(`RSC_CMD_TX);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			sbit <= 1'($urandom());
			repeat (6) @(posedge clk);
			#1 check(tx_bit, sbit);
		end
		ev(1'b1, TX);
		// host ends a stream with standby
		cmd(`RSC_CMD_ON);
		cmd(`RSC_CMD_RX);
		ev(1'b0, RX);
		cmd(`RSC_CMD_ON);
		wr(`RSC_CTRL_IDX, 8'h00);
		cnts();
		// sleep keeps pins quiet and ignores standby
		cmd(`RSC_CMD_SLEEP);
		#1 check({gpio_oe, irq, miso, pwr}, 11'h080);
		cmd(`RSC_CMD_ON);
		st(SL, 1'b0, 1'b0);
		// timer wake is no power-on reset
		wake_req <= 1'b1;
		repeat (8) @(posedge clk);
		wake_req <= 1'b0;
		st(OF, 1'b0, 1'b0);
		cmd(`RSC_CMD_SLEEP);
		// host lowers chip select and waits for miso
		cs_req <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check(miso, 1'b1);
		st(OF, 1'b0, 1'b0);
		rd(`RSC_CHAN_HI_IDX, {24'h00_0000, ch[23:16]});
		cs_req <= 1'b0;
		// let the raised select pass the synchroniser, else it wakes the device at once
		repeat (4) @(posedge clk);
		// full power down loses config and stops the timer
		cmd(`RSC_CMD_POWER_DOWN);
		st(SL, 1'b0, 1'b1);
		#1 check(pwr, 8'h00);
		wake_req <= 1'b1;
		repeat (8) @(posedge clk);
		wake_req <= 1'b0;
		st(SL, 1'b0, 1'b1);
		// shortened settle time before chip select
		repeat (200) @(posedge clk);
		cs_req <= 1'b1;
		repeat (8) @(posedge clk);
		cs_req <= 1'b0;
		st(OF, 1'b1, 1'b0);
		rd(`RSC_CHAN_HI_IDX, 32'h0000_0000);
		cmd(`RSC_CMD_CONFIG);
		ecnt[1]++;
		cnts();
		finish_test();
	end
endmodule
`default_nettype wire
